// ---- rtl/dbs_host.sv ----
// Host controller driving a two-word burst DDR SRAM through its pins.
// Notes on behaviour
// - Read is load low, select high.
// - Reads always complete; one per K rise.
// - Write is load low, select low.
// - First write word at next K rise.
// - Second write word at following K# rise.
// - Back-to-back writes pipeline one per K rise.
// - Active-low byte selects sampled per word.
// - C pair held high selects single clock.
// - At least one NOP from read to write.
// - Stopped clocks hold; park K equal, C high.
// - One load strobe per bank, rest shared.
// - PLL locks 20 us; stop 30 ns resets.
`timescale 1ns/100ps
`default_nettype none
module dbs_host #(
  parameter int DW = 18,
  parameter int NB = 2,
  parameter int AW = 21,
  parameter int BANKS = 1,
  parameter int RD_WR_NOPS = 1,
  parameter int SINGLE_CLK = 0,
  parameter int BKW = (BANKS > 1) ? $clog2(BANKS) : 1
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic PLL_OFF_I,
  input wire logic PLL_RESET_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic [BKW-1:0] REQ_BANK_I,
  input wire logic [AW-1:0] REQ_ADDR_I,
  input wire logic [2*DW-1:0] REQ_WDATA_I,
  input wire logic [2*NB-1:0] REQ_BYTE_EN_I,
  output logic RD_VALID_O,
  output logic [2*DW-1:0] RD_DATA_O,
  output logic LOCKED_O,
  output logic K_O,
  output logic KN_O,
  output logic C_O,
  output logic CN_O,
  output logic [BANKS-1:0] CMD_LOAD_N_O,
  output logic RW_O,
  output logic [AW-1:0] ADDR_O,
  output logic [DW-1:0] DQ_O,
  output logic DQ_OE_N_O,
  input wire logic [DW-1:0] DQ_I,
  output logic [NB-1:0] BYTE_LANE_WRITE_SEL_N_O,
  output logic PLL_ENABLE_N_PIN_O
);
  if (DW != NB * 9 || BANKS < 1 || RD_WR_NOPS < 1 || RD_WR_NOPS > 3) begin : g_bad_cfg
    $error("dbs_host: unsupported width, bank or gap setting");
  end

  // ===========================================================================
  // Reset release, strap capture and pin synchronisers
  // ===========================================================================
  logic rst_meta_ff, rst_b_ff;
  logic strap_done_ff, pll_off_ff;
  logic [DW-1:0] dq_s1_ff, dq_s2_ff;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_b_ff <= rst_meta_ff;
    end
  end

  // The PLL mode is a strap: taken once after reset release, never again.
  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      strap_done_ff <= 1'b0;
      pll_off_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      pll_off_ff <= PLL_OFF_I;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else begin
      dq_s1_ff <= DQ_I;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // ===========================================================================
  // Clock generator
  // ===========================================================================
  dbs_link_if lk ();

  dbs_clkgen #(.SINGLE_CLK(SINGLE_CLK)) u_clkgen (
    .clk_i(MCLK_I),
    .rst_b_i(rst_b_ff),
    .lk(lk)
  );

  // ===========================================================================
  // Command slot decode
  // ===========================================================================
  function automatic logic [BANKS-1:0] bank_strobe_n(input logic [BKW-1:0] bank);
    logic [BANKS-1:0] sel;
    sel = '1;
    for (int i = 0; i < BANKS; i++) begin
      if (BKW'(i) == bank) sel[i] = 1'b0;
    end
    return sel;
  endfunction

  logic [BANKS-1:0] ld_n_ff;
  logic rw_ff;
  logic [AW-1:0] addr_ff;
  logic [2*DW-1:0] wd_ff, wd_p1_ff;
  logic [2*NB-1:0] be_ff, be_p1_ff;
  logic wr_p1_ff;
  logic [1:0] gap_ff;
  logic stop_pend_ff;
  localparam int RD_SR_W = dbs_pkg::RD_SR_LEN;
  logic [RD_SR_W-1:0] rd_sr_ff;

  wire slot = lk.locked && (lk.cnt == dbs_pkg::PH_CMD);
  wire at_k_rise = lk.cnt == dbs_pkg::PH_K_RISE;
  wire ld_any = !(&ld_n_ff);
  wire rd_cmd = ld_any && rw_ff;
  wire wr_cmd = ld_any && !rw_ff;
  wire wr_allowed = (gap_ff == 2'h0);
  wire take = REQ_VALID_I && REQ_READY_O;

  assign REQ_READY_O = slot && !stop_pend_ff && (!REQ_WRITE_I || wr_allowed);

  // Commands change at mid cycle so they are stable at the K rise.
  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      ld_n_ff <= '1;
      rw_ff <= 1'b1;
      addr_ff <= '0;
      wd_ff <= '0;
      be_ff <= '0;
    end else if (slot) begin
      ld_n_ff <= take ? bank_strobe_n(REQ_BANK_I) : '1;
      if (take) begin
        rw_ff <= !REQ_WRITE_I;
        addr_ff <= REQ_ADDR_I;
        wd_ff <= REQ_WDATA_I;
        be_ff <= REQ_BYTE_EN_I;
      end
    end
  end

  // Read-to-write spacing: each read slot arms the NOP count.
  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      gap_ff <= 2'h0;
    end else if (slot) begin
      if (take && !REQ_WRITE_I) begin
        gap_ff <= 2'(RD_WR_NOPS);
      end else if (gap_ff != 2'h0) begin
        gap_ff <= gap_ff - 2'h1;
      end
    end
  end

  // A PLL reset request waits for idle; the request set wins over its clear.
  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      stop_pend_ff <= 1'b0;
    end else begin
      stop_pend_ff <= PLL_RESET_I || (stop_pend_ff && !lk.stopped);
    end
  end

  assign lk.stop_req = stop_pend_ff;
  assign lk.idle = !ld_any && !wr_p1_ff && (rd_sr_ff == '0);

  // ===========================================================================
  // Write data path
  // ===========================================================================
  logic [DW-1:0] dq_ff;
  logic dq_oe_n_ff;
  logic [NB-1:0] bws_n_ff;

  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      wr_p1_ff <= 1'b0;
      wd_p1_ff <= '0;
      be_p1_ff <= '0;
    end else if (slot) begin
      wr_p1_ff <= wr_cmd;
      wd_p1_ff <= wd_ff;
      be_p1_ff <= be_ff;
    end
  end

  // Word one is centred on the K rise, word two on the K# rise.
  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      dq_ff <= '0;
      dq_oe_n_ff <= 1'b1;
      bws_n_ff <= '1;
    end else if (lk.cnt == dbs_pkg::PH_WD1) begin
      dq_ff <= wd_p1_ff[DW-1:0];
      dq_oe_n_ff <= !wr_p1_ff;
      bws_n_ff <= wr_p1_ff ? ~be_p1_ff[NB-1:0] : '1;
    end else if (lk.cnt == dbs_pkg::PH_WD2 && wr_p1_ff) begin
      dq_ff <= wd_p1_ff[2*DW-1:DW];
      bws_n_ff <= ~be_p1_ff[2*NB-1:NB];
    end
  end

  // ===========================================================================
  // Read capture
  // ===========================================================================
  logic [2*DW-1:0] rdata_ff;
  logic rd_valid_ff;

  wire cap1 = pll_off_ff ? rd_sr_ff[dbs_pkg::CAP1_SDR] : rd_sr_ff[dbs_pkg::CAP1_DLL];
  wire cap2 = pll_off_ff ? rd_sr_ff[dbs_pkg::CAP2_SDR] : rd_sr_ff[dbs_pkg::CAP2_DLL];

  always_ff @(posedge MCLK_I or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      rd_sr_ff <= '0;
      rdata_ff <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_sr_ff <= {rd_sr_ff[RD_SR_W-2:0], lk.locked && at_k_rise && rd_cmd};
      if (cap1) rdata_ff[DW-1:0] <= dq_s2_ff;
      if (cap2) rdata_ff[2*DW-1:DW] <= dq_s2_ff;
      rd_valid_ff <= cap2;
    end
  end

  // ===========================================================================
  // Pins
  // ===========================================================================
  assign K_O = lk.k;
  assign KN_O = lk.kn;
  assign C_O = lk.c;
  assign CN_O = lk.cn;
  assign CMD_LOAD_N_O = ld_n_ff;
  assign RW_O = rw_ff;
  assign ADDR_O = addr_ff;
  assign DQ_O = dq_ff;
  assign DQ_OE_N_O = dq_oe_n_ff;
  assign BYTE_LANE_WRITE_SEL_N_O = bws_n_ff;
  assign PLL_ENABLE_N_PIN_O = !pll_off_ff;
  assign RD_VALID_O = rd_valid_ff;
  assign RD_DATA_O = rdata_ff;
  assign LOCKED_O = lk.locked;

  // ===========================================================================
  // Checks
  // ===========================================================================
  localparam int LAT_DLL = dbs_pkg::RD_LAT_DLL;
  localparam int LAT_SDR = dbs_pkg::RD_LAT_SDR;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_b_ff);

  sequence wr_smp_s;
    lk.locked && at_k_rise && wr_cmd;
  endsequence
  sequence rd_smp_s;
    lk.locked && at_k_rise && rd_cmd;
  endsequence

  ld_phase_a: assert property ($changed(ld_n_ff) |-> $past(lk.cnt) == dbs_pkg::PH_CMD)
    else $error("load strobe moved outside the command phase");
  rd_wr_gap_a: assert property ((lk.cnt == dbs_pkg::PH_K_RISE && wr_cmd) |->
    !$past(rd_cmd, 8)) else $error("write directly follows a read");
  wr_word1_a: assert property (wr_smp_s |-> ##7 (!DQ_OE_N_O &&
    DQ_O == $past(wd_ff[DW-1:0], 7))) else $error("first write word wrong");
  wr_word2_a: assert property (wr_smp_s |-> ##11 (!DQ_OE_N_O &&
    DQ_O == $past(wd_ff[2*DW-1:DW], 11))) else $error("second write word wrong");
  byte_sel_a: assert property (wr_smp_s |->
    ##7 (BYTE_LANE_WRITE_SEL_N_O == ~$past(be_ff[NB-1:0], 7))
    ##4 (BYTE_LANE_WRITE_SEL_N_O == ~$past(be_ff[2*NB-1:NB], 11)))
    else $error("byte selects wrong");
  rd_lat_a: assert property ((rd_smp_s and !pll_off_ff) |-> ##LAT_DLL RD_VALID_O)
    else $error("read data not returned on time");
  rd_lat_sdr_a: assert property ((rd_smp_s and pll_off_ff) |-> ##LAT_SDR RD_VALID_O)
    else $error("one-cycle read data not returned on time");
  nop_slot_a: assert property ((slot && !take) |=> &CMD_LOAD_N_O)
    else $error("load strobe low without a request");
  one_bank_a: assert property ($onehot0(~CMD_LOAD_N_O))
    else $error("more than one bank loaded");
endmodule
`default_nettype wire

// ---- rtl/dbs_pkg.sv ----
// Shared constants and types of the burst SRAM host controller.
package dbs_pkg;
  // ===========================================================================
  // Link clock phases (one memory clock cycle is K_DIV system cycles)
  // ===========================================================================
  localparam int K_DIV = 8;
  localparam logic [2:0] PH_K_RISE = 3'h0;
  localparam logic [2:0] PH_WD2 = 3'h2;
  localparam logic [2:0] PH_HALF = 3'h4;
  localparam logic [2:0] PH_CMD = 3'h4;
  localparam logic [2:0] PH_WD1 = 3'h6;
  localparam logic [2:0] PH_LAST = 3'h7;
  // ===========================================================================
  // Times and derived cycle counts
  // ===========================================================================
  localparam int SYS_PERIOD_PS = 25000;
  localparam int PLL_LOCK_US = 20;
  localparam int PLL_STOP_NS = 30;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int PLL_STOP_CYC = (PLL_STOP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] TMR_RST = 10'h000;
  // ===========================================================================
  // Read capture points, counted from the cycle after the sampling K rise
  // ===========================================================================
  localparam int SYNC_LAT = 2;
  localparam int CAP1_DLL = K_DIV + K_DIV / 2 + K_DIV / 2 - SYNC_LAT;
  localparam int CAP2_DLL = 2 * K_DIV + K_DIV / 2 - SYNC_LAT;
  localparam int CAP1_SDR = K_DIV + K_DIV / 2 - SYNC_LAT;
  localparam int CAP2_SDR = CAP1_DLL;
  localparam int RD_SR_LEN = CAP2_DLL + 1;
  localparam int RD_LAT_DLL = CAP2_DLL + 2;
  localparam int RD_LAT_SDR = CAP2_SDR + 2;
  typedef enum logic [1:0] {CLK_LOCK, CLK_RUN, CLK_STOP} dbs_clk_st_t;
endpackage

// ---- rtl/dbs_link_if.sv ----
// Interface between the clock generator and the command core.
`timescale 1ns/100ps
`default_nettype none
interface dbs_link_if;
  logic [2:0] cnt;
  logic k;
  logic kn;
  logic c;
  logic cn;
  logic locked;
  logic stopped;
  logic stop_req;
  logic idle;
  modport gen (output cnt, k, kn, c, cn, locked, stopped, input stop_req, idle);
  modport core (input cnt, k, kn, c, cn, locked, stopped, output stop_req, idle);
endinterface
`default_nettype wire

// ---- rtl/dbs_clkgen.sv ----
// Memory clock generator with PLL stop and lock timing.
`timescale 1ns/100ps
`default_nettype none
module dbs_clkgen #(
  parameter int SINGLE_CLK = 0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  dbs_link_if.gen lk
);
  // ===========================================================================
  // State and timers
  // ===========================================================================
  dbs_pkg::dbs_clk_st_t st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [dbs_pkg::TMR_W-1:0] tmr_ff;
  logic k_ff, kn_ff, c_ff, cn_ff;
  wire tmr_stop_done = (tmr_ff == dbs_pkg::TMR_W'(dbs_pkg::PLL_STOP_CYC - 1));
  wire tmr_lock_done = (tmr_ff == dbs_pkg::TMR_W'(dbs_pkg::PLL_LOCK_CYC - 1));
  wire run_clk = (nxt_st != dbs_pkg::CLK_STOP);

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      dbs_pkg::CLK_LOCK: if (tmr_lock_done) nxt_st = dbs_pkg::CLK_RUN;
      dbs_pkg::CLK_RUN: begin
        if (lk.stop_req && lk.idle && cnt_ff == dbs_pkg::PH_LAST) begin
          nxt_st = dbs_pkg::CLK_STOP;
        end
      end
      dbs_pkg::CLK_STOP: if (tmr_stop_done) nxt_st = dbs_pkg::CLK_LOCK;
      default: nxt_st = dbs_pkg::CLK_LOCK;
    endcase
  end

  assign nxt_cnt = (st_ff == dbs_pkg::CLK_STOP) ? 3'h0 : cnt_ff + 3'h1;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= dbs_pkg::CLK_LOCK;
      cnt_ff <= dbs_pkg::PH_LAST;
      tmr_ff <= dbs_pkg::TMR_RST;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      tmr_ff <= (nxt_st != st_ff) ? dbs_pkg::TMR_RST : tmr_ff + 10'h001;
    end
  end

  // Parked clocks: K and K# equal and low, C and C# high.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      k_ff <= 1'b0;
      kn_ff <= 1'b0;
      c_ff <= 1'b1;
      cn_ff <= 1'b1;
    end else begin
      k_ff <= run_clk && (nxt_cnt < dbs_pkg::PH_HALF);
      kn_ff <= run_clk && (nxt_cnt >= dbs_pkg::PH_HALF);
      c_ff <= (SINGLE_CLK != 0) || !run_clk || (nxt_cnt < dbs_pkg::PH_HALF);
      cn_ff <= (SINGLE_CLK != 0) || !run_clk || (nxt_cnt >= dbs_pkg::PH_HALF);
    end
  end

  assign lk.cnt = cnt_ff;
  assign lk.k = k_ff;
  assign lk.kn = kn_ff;
  assign lk.c = c_ff;
  assign lk.cn = cn_ff;
  assign lk.locked = (st_ff == dbs_pkg::CLK_RUN);
  assign lk.stopped = (st_ff == dbs_pkg::CLK_STOP);

  // ===========================================================================
  // Checks
  // ===========================================================================
  strap_high_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (c_ff && cn_ff) == ((SINGLE_CLK != 0) || !(k_ff || kn_ff)))
    else $error("C pair wrong for the clock mode");
  park_equal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    lk.stopped |-> (k_ff == kn_ff && c_ff && cn_ff)) else $error("clocks not parked");
  stop_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(lk.stopped) |-> lk.stopped[*2] ##1 !lk.stopped) else $error("bad PLL stop length");
endmodule
`default_nettype wire

// ---- dv/dbs_sram_model.sv ----
// Pin-level model of the two-word burst DDR SRAM driven by the host.
`timescale 1ns/100ps
`default_nettype none
module dbs_sram_model #(
  parameter int DW = 18,
  parameter int NB = 2,
  parameter int AW = 21
) (
  input wire logic k_i,
  input wire logic kn_i,
  input wire logic c_i,
  input wire logic cn_i,
  input wire logic load_n_i,
  input wire logic rw_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] d_i,
  input wire logic d_oe_n_i,
  input wire logic [NB-1:0] byte_lane_write_sel_n_i,
  input wire logic pll_enable_n_pin_i,
  output logic [DW-1:0] dq_o,
  output logic echo_clk_o,
  output logic echo_clk_n_o,
  output int clash_o
);
  localparam int LW = DW / NB;
  logic [DW-1:0] mem [0:63];
  logic [DW-1:0] q = '0;
  logic q_oe = 1'b0;
  logic strap = 1'b1;
  int tok = 0;
  wire oc = strap ? k_i : c_i;
  wire ocn = strap ? kn_i : cn_i;
  assign echo_clk_o = oc;
  assign echo_clk_n_o = ocn;
  // A released bus shows the inverse of the last word, so stale data never passes.
  assign dq_o = q_oe ? q : ((d_oe_n_i === 1'b0) ? d_i : ~q);
  initial begin
    clash_o = 0;
    for (int i = 0; i < 64; i++) mem[i] = '0;
  end
  always @(negedge c_i or negedge cn_i) strap = 1'b0;
  task automatic put(input logic [5:0] a, input logic [DW-1:0] d, input logic [NB-1:0] sel_n);
    for (int b = 0; b < NB; b++) if (sel_n[b] == 1'b0) mem[a][b*LW +: LW] = d[b*LW +: LW];
  endtask
  // Words land in the array at once, which reads back like a posted write with bypass.
  task automatic do_write(input logic [5:0] a);
    @(posedge k_i);
    put(a, d_i, byte_lane_write_sel_n_i);
    @(posedge kn_i);
    put(a ^ 6'h01, d_i, byte_lane_write_sel_n_i);
  endtask
  task automatic do_read(input logic [5:0] a);
    int my;
    logic dll;
    @(posedge k_i);
    dll = pll_enable_n_pin_i;
    if (dll) @(posedge ocn);
    #1 q = mem[a];
    q_oe = 1'b1;
    tok = tok + 1;
    if (dll) @(posedge oc); else @(posedge ocn);
    #1 q = mem[a ^ 6'h01];
    tok = tok + 1;
    my = tok;
    @(posedge oc or posedge ocn);
    #2 if (tok == my) q_oe = 1'b0;
  endtask
  always @(posedge k_i) begin
    if (load_n_i === 1'b0) begin
      if (rw_i) fork do_read(addr_i[5:0]); join_none
      else fork do_write(addr_i[5:0]); join_none
    end
  end
  always @(q_oe or d_oe_n_i) if (q_oe && d_oe_n_i === 1'b0) clash_o = clash_o + 1;
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the burst SRAM host controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin checked++; if ((exp) !== (got)) begin n_fail++; $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb;
  localparam int DW = 18;
  localparam int AW = 21;
  logic MCLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic PLL_OFF_I = 1'b0;
  logic PLL_RESET_I = 1'b0;
  logic REQ_VALID_I = 1'b0;
  logic REQ_WRITE_I = 1'b0;
  logic [AW-1:0] REQ_ADDR_I = '0;
  logic [2*DW-1:0] REQ_WDATA_I = '0;
  logic [3:0] REQ_BYTE_EN_I = '0;
  wire REQ_READY_O, RD_VALID_O, LOCKED_O, K_O, KN_O, C_O, CN_O, RW_O, DQ_OE_N_O, PLL_ENABLE_N_PIN_O;
  wire [0:0] CMD_LOAD_N_O;
  wire [AW-1:0] ADDR_O;
  wire [DW-1:0] DQ_O, DQ_I;
  wire [1:0] BYTE_LANE_WRITE_SEL_N_O;
  wire [2*DW-1:0] RD_DATA_O;
  int clash, n_fail = 0, checked = 0, cyc = 0, seed = 53078, lat_dll = 0, lat_sdr = 0;
  logic [DW-1:0] mir [0:63];
  logic [2*DW-1:0] exp_q [$];
  int t_q [$];
  always #12.5 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) cyc <= cyc + 1;
  dbs_host dut (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .PLL_OFF_I(PLL_OFF_I),
    .PLL_RESET_I(PLL_RESET_I), .REQ_VALID_I(REQ_VALID_I), .REQ_READY_O(REQ_READY_O),
    .REQ_WRITE_I(REQ_WRITE_I), .REQ_BANK_I(1'b0), .REQ_ADDR_I(REQ_ADDR_I),
    .REQ_WDATA_I(REQ_WDATA_I), .REQ_BYTE_EN_I(REQ_BYTE_EN_I), .RD_VALID_O(RD_VALID_O),
    .RD_DATA_O(RD_DATA_O), .LOCKED_O(LOCKED_O), .K_O(K_O), .KN_O(KN_O), .C_O(C_O), .CN_O(CN_O),
    .CMD_LOAD_N_O(CMD_LOAD_N_O), .RW_O(RW_O), .ADDR_O(ADDR_O), .DQ_O(DQ_O),
    .DQ_OE_N_O(DQ_OE_N_O), .DQ_I(DQ_I), .BYTE_LANE_WRITE_SEL_N_O(BYTE_LANE_WRITE_SEL_N_O),
    .PLL_ENABLE_N_PIN_O(PLL_ENABLE_N_PIN_O));
  dbs_sram_model mem (.k_i(K_O), .kn_i(KN_O), .c_i(C_O), .cn_i(CN_O), .load_n_i(CMD_LOAD_N_O[0]),
    .rw_i(RW_O), .addr_i(ADDR_O), .d_i(DQ_O), .d_oe_n_i(DQ_OE_N_O),
    .byte_lane_write_sel_n_i(BYTE_LANE_WRITE_SEL_N_O), .pll_enable_n_pin_i(PLL_ENABLE_N_PIN_O),
    .dq_o(DQ_I), .echo_clk_o(), .echo_clk_n_o(), .clash_o(clash));
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Read results
  // ==========================================================================
  always @(negedge MCLK_I) begin
    if (RD_VALID_O === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("CHECK FAILED read data expected none seen %h", RD_DATA_O);
      end else begin
        `CHK("read data", exp_q[0], RD_DATA_O)
        if (PLL_OFF_I) lat_sdr = cyc - t_q[0];
        else lat_dll = cyc - t_q[0];
        void'(exp_q.pop_front());
        void'(t_q.pop_front());
      end
    end
  end
  // ==========================================================================
  // Stimulus tasks
  // ==========================================================================
  task automatic req(input logic wr, input logic [5:0] a, input logic [35:0] wd,
                     input logic [3:0] be);
    int n;
    logic [5:0] b;
    REQ_VALID_I = 1'b1;
    REQ_WRITE_I = wr;
    REQ_ADDR_I = {15'($random(seed)), a};
    REQ_WDATA_I = wd;
    REQ_BYTE_EN_I = be;
    n = 0;
    #1;
    while (REQ_READY_O !== 1'b1 && n < 64) begin
      @(negedge MCLK_I);
      #1;
      n++;
    end
    if (n == 64) begin
      n_fail++;
      $display("CHECK FAILED request ready expected 1 seen %b", REQ_READY_O);
    end
    @(negedge MCLK_I);
    for (int i = 0; i < 4; i++) begin
      b = (i < 2) ? a : a ^ 6'h01;
      if (wr && be[i]) mir[b][(i%2)*9 +: 9] = wd[i*9 +: 9];
    end
    if (!wr) begin
      exp_q.push_back({mir[a ^ 6'h01], mir[a]});
      t_q.push_back(cyc);
    end
  endtask
  task automatic idle(input int n);
    REQ_VALID_I = 1'b0;
    repeat (n) @(negedge MCLK_I);
  endtask
  task automatic rnd_ops(input int n);
    for (int i = 0; i < n; i++) begin
      req(1'($random(seed)), 6'($random(seed)), 36'({$random(seed), $random(seed)}),
          4'($random(seed)));
    end
  endtask
  task automatic do_reset(input logic off);
    int n;
    @(negedge MCLK_I);
    RST_B_I = 1'b0;
    PLL_OFF_I = off;
    repeat (2) @(negedge MCLK_I);
    `CHK("reset pins", 11'h1fd, {K_O, KN_O, C_O, CN_O, CMD_LOAD_N_O, RW_O, DQ_OE_N_O, BYTE_LANE_WRITE_SEL_N_O, REQ_READY_O, PLL_ENABLE_N_PIN_O})
    RST_B_I = 1'b1;
    n = 0;
    while (LOCKED_O !== 1'b1 && n < 2000) begin
      @(negedge MCLK_I);
      n++;
    end
    `CHK("lock wait", 1'b1, n >= dbs_pkg::PLL_LOCK_CYC && LOCKED_O === 1'b1)
    `CHK("pll pin", ~off, PLL_ENABLE_N_PIN_O)
  endtask
  task automatic pll_restart();
    int n, stop, park;
    logic low;
    PLL_RESET_I = 1'b1;
    @(negedge MCLK_I);
    PLL_RESET_I = 1'b0;
    n = 0;
    stop = 0;
    park = 0;
    low = 1'b0;
    while (!(low && LOCKED_O === 1'b1) && n < 1500) begin
      @(negedge MCLK_I);
      n++;
      if (LOCKED_O === 1'b0) low = 1'b1;
      if (K_O === 1'b0 && KN_O === 1'b0) stop++;
      if (K_O === 1'b0 && KN_O === 1'b0 && (C_O !== 1'b1 || CN_O !== 1'b1)) park++;
    end
    `CHK("clock stop", 1'b1, stop >= dbs_pkg::PLL_STOP_CYC)
    `CHK("park level", 0, park)
    `CHK("relock time", 1'b1, n > dbs_pkg::PLL_LOCK_CYC && LOCKED_O === 1'b1)
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    for (int i = 0; i < 64; i++) mir[i] = '0;
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) req(1'b1, 6'(i*5), 36'({$random(seed), $random(seed)}), 4'hf);
    for (int i = 0; i < 6; i++) req(1'b0, 6'(i*5), 36'h0, 4'h0);
    req(1'b1, 6'h11, 36'({$random(seed), $random(seed)}), 4'hf);
    req(1'b0, 6'h11, 36'h0, 4'h0);
    for (int m = 0; m < 16; m++) begin
      req(1'b1, 6'h20, 36'({$random(seed), $random(seed)}), 4'(m));
      req(1'b0, 6'h20, 36'h0, 4'h0);
    end
    rnd_ops(60);
    idle(60);
    `CHK("idle strobe", 1'b1, CMD_LOAD_N_O[0])
    `CHK("idle bus release", 1'b1, DQ_OE_N_O)
    pll_restart();
    for (int i = 0; i < 4; i++) req(1'b0, 6'(i*5), 36'h0, 4'h0);
    idle(60);
    do_reset(1'b1);
    for (int i = 0; i < 4; i++) req(1'b0, 6'(i*5+1), 36'h0, 4'h0);
    rnd_ops(30);
    idle(60);
    `CHK("latency step", dbs_pkg::K_DIV / 2, lat_dll - lat_sdr)
    `CHK("results drained", 0, exp_q.size())
    `CHK("bus clash", 0, clash)
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge MCLK_I);
    n_fail++;
    $display("CHECK FAILED watchdog expected end seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
